/* hdl/addr_gen_pkg.sv */
// Summary of operation
// - multi-byte data sits in consecutive bytes, least significant byte lowest
// - a word or dword address is the address of its lowest byte
// - paged memory uses fixed 4 Kbyte pages
// - with paging off the linear address goes out unchanged as physical
// - real mode linear address is selector shifted left four plus offset
// - protected mode linear address is segment base plus offset
// - defaults: code segment for fetches, stack for stack, data segment for data
// - code fetch and push/pop stack accesses ignore any override
// - string store destinations always use extra segment, no override
// - other data: frame or stack pointer base means stack segment, else data
// - an override replaces the default where allowed, any of six segments
// - all six segments may share base zero for a flat space
// - segment limits range from one byte to four gigabytes; addr_gen does not check limits
// - I/O space is 64 Kbytes, bypasses segmentation and paging
// - byte, halfword and word ports may be mixed freely
// - I/O accesses drive the memory/io select output low
// - port address from 8-bit immediate or port index, zero extended
// - effective address is base plus scaled index plus displacement
// - displacement is 8 or 32 bits, the 8-bit form sign extended
// - index may not be the stack pointer; scale is 1, 2, 4 or 8
// - base plus index together costs one extra clock, else none
`default_nettype none

package addr_gen_pkg;

    localparam int ADDR_W = 32;
    localparam int PORT_W = 16;
    localparam int SEL_W = 16;
    localparam int REAL_SHIFT = 4;
    localparam int PAGE_OFS_W = 12;
    localparam int GPR_W = 3;
    localparam logic [GPR_W-1:0] STACK_POINTER_IDX = 3'h4;
    localparam logic [GPR_W-1:0] FRAME_POINTER_IDX = 3'h5;
    localparam logic [PORT_W-1:0] RESERVED_PORT_LO = 16'h00F8;
    localparam logic [PORT_W-1:0] RESERVED_PORT_HI = 16'h00FF;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h0000_0000;

    typedef enum logic [2:0] {
        SEG_EXTRA, SEG_CODE, SEG_STACK, SEG_DATA, SEG_AUX_ONE, SEG_AUX_TWO
    } seg_t;

    typedef enum logic [2:0] {
        REF_CODE, REF_STACK_PUSH, REF_STACK_POP, REF_STRING_DST, REF_DATA, REF_IO
    } ref_t;

    typedef enum logic [1:0] {DISP_NONE, DISP_8, DISP_32} disp_t;
    typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} size_t;

    typedef struct packed {
        ref_t kind;
        logic use_base;
        logic [GPR_W-1:0] base_idx;
        logic use_index;
        logic [GPR_W-1:0] index_idx;
        logic [1:0] scale_log2;
        disp_t disp_kind;
        logic [ADDR_W-1:0] disp;
        logic ovr_valid;
        seg_t ovr_seg;
        logic io_imm;
        logic [7:0] io_imm_port;
        size_t size;
    } req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] phys;
        logic [ADDR_W-1:0] linear;
        logic [ADDR_W-1:0] offset;
        seg_t seg;
        logic mem_io_n;
        logic [3:0] byte_en;
        logic io_reserved;
    } resp_t;

endpackage : addr_gen_pkg

`default_nettype wire

/* hdl/ea_adder.sv */
`default_nettype none

module ea_adder
    import addr_gen_pkg::*;
(
    input wire logic [addr_gen_pkg::ADDR_W-1:0] base_val, // base operand or zero
    input wire logic [addr_gen_pkg::ADDR_W-1:0] index_val, // index operand or zero
    input wire logic [1:0] scale_log2, // scale 1,2,4,8
    input wire logic [addr_gen_pkg::ADDR_W-1:0] disp_val, // already extended
    output logic [addr_gen_pkg::ADDR_W-1:0] sum // wrapping sum
);
    // shift-then-add, carries past bit 31 dropped
    always_comb begin
        sum = base_val + (index_val << scale_log2) + disp_val;
    end
endmodule : ea_adder

`default_nettype wire

/* hdl/addr_gen.sv */
`default_nettype none

module addr_gen
    import addr_gen_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic sys_rst, // async reset, active high
    input wire logic req_valid, // request present
    output logic req_ready, // request taken this cycle
    input wire addr_gen_pkg::req_t req, // request fields
    input wire logic [addr_gen_pkg::ADDR_W-1:0] gpr [8], // general registers
    input wire logic [addr_gen_pkg::ADDR_W-1:0] instr_ptr, // instruction pointer
    input wire logic [addr_gen_pkg::SEL_W-1:0] seg_sel [6], // selectors by seg_t
    input wire logic [addr_gen_pkg::ADDR_W-1:0] seg_base [6], // descriptor bases
    input wire logic protected_mode, // 1 = protected mode
    input wire logic paging_en, // paging unit on
    input wire logic [addr_gen_pkg::ADDR_W-1:0] page_frame, // frame from translator
    output logic resp_valid, // answer pulse
    output addr_gen_pkg::resp_t resp, // registered answer
    output logic index_fault // stack pointer used as index, pulse
);
    import addr_gen_pkg::*;

    // ======================================================
    // helpers
    function automatic logic [ADDR_W-1:0] ext_disp(input disp_t k, input logic [ADDR_W-1:0] d);
        case (k)
            DISP_8: ext_disp = {{(ADDR_W-8){d[7]}}, d[7:0]};
            DISP_32: ext_disp = d;
            default: ext_disp = ADDR_ZERO;
        endcase
    endfunction : ext_disp

    function automatic logic [3:0] lane_mask(input size_t s, input logic [1:0] a);
        logic [6:0] m;
        m = 7'h00;
        case (s)
            SIZE_HALF: m = 7'h03;
            SIZE_WORD: m = 7'h0F;
            default: m = 7'h01;
        endcase
        // lowest byte at the given address, higher bytes above it
        m = m << a;
        lane_mask = m[3:0];
    endfunction : lane_mask

    // ======================================================
    // segment choice
    seg_t seg_sel_w;
    always_comb begin
        seg_sel_w = SEG_DATA;
        case (req.kind)
            REF_CODE: seg_sel_w = SEG_CODE;
            REF_STACK_PUSH, REF_STACK_POP: seg_sel_w = SEG_STACK;
            REF_STRING_DST: seg_sel_w = SEG_EXTRA;
            REF_DATA: begin
                if (req.ovr_valid) begin
                    seg_sel_w = req.ovr_seg;
                end else if (req.use_base && (req.base_idx == FRAME_POINTER_IDX
                        || req.base_idx == STACK_POINTER_IDX)) begin
                    seg_sel_w = SEG_STACK;
                end else begin
                    seg_sel_w = SEG_DATA;
                end
            end
            default: seg_sel_w = SEG_DATA;
        endcase
    end

    // ======================================================
    // effective address
    logic [ADDR_W-1:0] base_w, index_w, disp_w, ea_w, off_w;
    logic bad_index_w;
    always_comb begin
        base_w = req.use_base ? gpr[req.base_idx] : ADDR_ZERO;
        index_w = req.use_index ? gpr[req.index_idx] : ADDR_ZERO;
        disp_w = ext_disp(req.disp_kind, req.disp);
        if (req.kind == REF_STRING_DST) begin
            // destination index register is the fixed base
            base_w = gpr[req.base_idx];
            index_w = ADDR_ZERO;
            disp_w = ADDR_ZERO;
        end
        bad_index_w = req.kind == REF_DATA && req.use_index
            && req.index_idx == STACK_POINTER_IDX;
    end

    ea_adder u_ea (
        .base_val(base_w),
        .index_val(index_w),
        .scale_log2(req.scale_log2),
        .disp_val(disp_w),
        .sum(ea_w)
    );

    always_comb begin
        off_w = (req.kind == REF_CODE) ? instr_ptr : ea_w;
    end

    // ======================================================
    // linear and physical
    logic [ADDR_W-1:0] lin_w, phys_w, port_w;
    always_comb begin
        if (protected_mode) begin
            // any bases accepted, overlap or all zero alike; limits not checked here
            lin_w = seg_base[seg_sel_w] + off_w;
        end else begin
            lin_w = ({{(ADDR_W-SEL_W){1'b0}}, seg_sel[seg_sel_w]} << REAL_SHIFT)
                + off_w;
        end
        if (paging_en) begin
            phys_w = {page_frame[ADDR_W-1:PAGE_OFS_W], lin_w[PAGE_OFS_W-1:0]};
        end else begin
            phys_w = lin_w;
        end
        if (req.io_imm) begin
            port_w = {{(ADDR_W-8){1'b0}}, req.io_imm_port};
        end else begin
            port_w = {{(ADDR_W-PORT_W){1'b0}}, gpr[req.base_idx][PORT_W-1:0]};
        end
    end

    // ======================================================
    // pipeline: base plus index takes a second cycle
    logic wait_q, wait_d;
    logic two_cycle_w;
    logic take_w;
    always_comb begin
        two_cycle_w = req.kind == REF_DATA && req.use_base && req.use_index;
        wait_d = 1'b0;
        if (req_valid && two_cycle_w && !wait_q) begin
            wait_d = 1'b1;
        end
        take_w = req_valid && (!two_cycle_w || wait_q);
        req_ready = take_w;
    end

    resp_t resp_d;
    logic resp_valid_d, fault_d;
    always_comb begin
        resp_d = resp;
        resp_valid_d = take_w;
        fault_d = take_w && bad_index_w;
        if (take_w) begin
            if (req.kind == REF_IO) begin
                // ports bypass segment and page logic
                resp_d.phys = port_w;
                resp_d.linear = port_w;
                resp_d.offset = port_w;
                resp_d.seg = SEG_DATA;
                resp_d.mem_io_n = 1'b0;
                resp_d.byte_en = lane_mask(req.size, port_w[1:0]);
                resp_d.io_reserved = port_w[PORT_W-1:0] >= RESERVED_PORT_LO
                    && port_w[PORT_W-1:0] <= RESERVED_PORT_HI;
            end else begin
                resp_d.phys = phys_w;
                resp_d.linear = lin_w;
                resp_d.offset = off_w;
                resp_d.seg = seg_sel_w;
                resp_d.mem_io_n = 1'b1;
                resp_d.byte_en = lane_mask(req.size, phys_w[1:0]);
                resp_d.io_reserved = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_q <= 1'b0;
            resp_valid <= 1'b0;
            index_fault <= 1'b0;
            resp <= '{phys: ADDR_ZERO, linear: ADDR_ZERO, offset: ADDR_ZERO,
                seg: SEG_DATA, mem_io_n: 1'b1, byte_en: 4'h0, io_reserved: 1'b0};
        end else begin
            wait_q <= wait_d;
            resp_valid <= resp_valid_d;
            index_fault <= fault_d;
            resp <= resp_d;
        end
    end

    // ======================================================
    // checks: address space and port address
    AST_IO_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && req.kind == REF_IO |=> !resp.mem_io_n)
        else $error("io access did not drive select low");
    AST_MEM_HIGH: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && req_ready && req.kind != REF_IO |=> resp.mem_io_n)
        else $error("memory access drove select low");
    AST_IO_IMM: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_IO && req.io_imm
        |=> resp.phys == ADDR_W'($past(req.io_imm_port)))
        else $error("immediate port address wrong");
    AST_IO_INDEX: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_IO && !req.io_imm
        |=> resp.phys == ADDR_W'($past(gpr[req.base_idx][PORT_W-1:0])))
        else $error("indexed port address wrong");
    AST_PORT_ZX: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_IO |=> resp.phys[ADDR_W-1:PORT_W] == '0)
        else $error("port address not zero extended");
    AST_IO_RSVD: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_IO && req.io_imm
        && req.io_imm_port >= RESERVED_PORT_LO[7:0] |=> resp.io_reserved)
        else $error("reserved port not flagged");
    AST_MEM_NOT_RSVD: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind != REF_IO |=> !resp.io_reserved)
        else $error("memory cycle flagged as reserved port");
    // ======================================================
    // checks: segment choice
    AST_CODE_SEG: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_CODE |=> resp.seg == SEG_CODE)
        else $error("code fetch not in code segment");
    AST_STACK_SEG: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && (req.kind == REF_STACK_PUSH || req.kind == REF_STACK_POP)
        |=> resp.seg == SEG_STACK)
        else $error("stack access not in stack segment");
    AST_STR_SEG: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_STRING_DST |=> resp.seg == SEG_EXTRA)
        else $error("string destination not in extra segment");
    AST_FRAME_SEG: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_DATA && !req.ovr_valid && req.use_base
        && req.base_idx == FRAME_POINTER_IDX |=> resp.seg == SEG_STACK)
        else $error("frame pointer base not in stack segment");
    AST_OVR_SEG: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_DATA && req.ovr_valid
        |=> resp.seg == $past(req.ovr_seg))
        else $error("override segment not used");
    // ======================================================
    // checks: offsets and faults
    AST_CODE_OFS: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_CODE |=> resp.offset == $past(instr_ptr))
        else $error("code fetch offset is not the instruction pointer");
    AST_STR_OFS: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_STRING_DST
        |=> resp.offset == $past(gpr[req.base_idx]))
        else $error("string destination offset wrong");
    AST_DISP8: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_DATA && !req.use_base && !req.use_index
        && req.disp_kind == DISP_8 |=> resp.offset[31:8] == {24{resp.offset[7]}})
        else $error("short displacement not sign extended");
    AST_INDEX_FAULT: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_DATA && req.use_index
        && req.index_idx == STACK_POINTER_IDX |=> index_fault)
        else $error("stack pointer index not flagged");
    AST_NO_FAULT: assert property (@(posedge clk) disable iff (sys_rst)
        !req_ready |=> !index_fault)
        else $error("index fault without a request");
    // ======================================================
    // checks: linear and physical
    AST_REAL_LIN: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && !protected_mode && req.kind != REF_IO
        |=> resp.linear == ((ADDR_W'($past(seg_sel[seg_sel_w])) << REAL_SHIFT)
        + resp.offset))
        else $error("real mode linear address wrong");
    AST_PROT_LIN: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && protected_mode && req.kind != REF_IO
        |=> resp.linear == $past(seg_base[seg_sel_w]) + resp.offset)
        else $error("protected mode linear address wrong");
    AST_FLAT: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && !paging_en && req.kind != REF_IO |=> resp.phys == resp.linear)
        else $error("physical differs from linear with paging off");
    AST_PAGED: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && paging_en && req.kind != REF_IO
        |=> resp.phys[PAGE_OFS_W-1:0] == resp.linear[PAGE_OFS_W-1:0])
        else $error("page offset not carried through");
    // ======================================================
    // checks: byte lanes
    AST_LANE_LOW: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready |=> resp.byte_en[resp.phys[1:0]])
        else $error("lowest byte lane not enabled");
    AST_WORD_LANES: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind != REF_IO && req.size == SIZE_WORD
        && phys_w[1:0] == 2'h0 |=> resp.byte_en == 4'hF)
        else $error("aligned word lanes wrong");
    // ======================================================
    // checks: timing
    AST_EXTRA_CLK: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !wait_q && req.kind == REF_DATA && req.use_base && req.use_index
        |-> !req_ready ##1 (!req_valid || req_ready))
        else $error("base plus index timing wrong");
    AST_SINGLE_CLK: assert property (@(posedge clk) disable iff (sys_rst)
        req_valid && !two_cycle_w |-> req_ready)
        else $error("single cycle request stalled");
    AST_RESP_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
        req_ready |=> resp_valid)
        else $error("taken request gave no answer");
    AST_RESP_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        !req_ready |=> !resp_valid)
        else $error("answer without a request");
    AST_RESP_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        !req_ready |=> $stable(resp))
        else $error("answer changed between requests");

    // ======================================================
    // coverage
    COV_IO: cover property (@(posedge clk) disable iff (sys_rst) req_ready && req.kind == REF_IO);
    COV_TWO: cover property (@(posedge clk) disable iff (sys_rst) wait_q && req_ready);
    COV_OVR: cover property (@(posedge clk) disable iff (sys_rst)
        req_ready && req.kind == REF_DATA && req.ovr_valid);
    COV_PAGE: cover property (@(posedge clk) disable iff (sys_rst) req_ready && paging_en);
    COV_REAL: cover property (@(posedge clk) disable iff (sys_rst)
        req_ready && !protected_mode && req.kind == REF_DATA);
endmodule : addr_gen

`default_nettype wire

/* dv/bus_far_side.sv */
`default_nettype none

module bus_far_side
    import addr_gen_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic sys_rst, // async reset, active high
    input wire logic resp_valid, // address cycle strobe
    input wire addr_gen_pkg::resp_t resp, // address and space select
    output logic port_claim_q // a peripheral took the last io cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    import addr_gen_pkg::*;

    // ==========================================
    // io peripheral decode
    logic port_claim_d;

    always_comb begin
        port_claim_d = port_claim_q;
        if (resp_valid && !resp.mem_io_n) begin
            // only 16 port lines exist; the reserved ports hold no peripheral
            port_claim_d = (resp.phys[31:16] == 16'h0000)
                && (resp.phys[15:0] < RESERVED_PORT_LO
                || resp.phys[15:0] > RESERVED_PORT_HI);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            port_claim_q <= 1'b0;
        end else begin
            port_claim_q <= port_claim_d;
        end
    end
endmodule : bus_far_side

`default_nettype wire

/* dv/segmented_address_generation_tb.sv */
`default_nettype none
`define CHK(nm, ex, got) begin tests_run++; if ((ex) !== (got)) begin fails++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module segmented_address_generation_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import addr_gen_pkg::*;

    logic clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0, protected_mode = 1'b0, paging_en = 1'b0;
    logic req_ready, resp_valid, index_fault, port_claim_q;
    req_t req = '0;
    resp_t resp;
    logic [ADDR_W-1:0] gpr [8];
    logic [ADDR_W-1:0] instr_ptr = 32'h0000_1230;
    logic [SEL_W-1:0] seg_sel [6];
    logic [ADDR_W-1:0] seg_base [6];
    logic [ADDR_W-1:0] page_frame = 32'h1234_5FFF;
    int fails = 0, tests_run = 0, cyc = 0, waits = 0;

    addr_gen dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .gpr(gpr), .instr_ptr(instr_ptr), .seg_sel(seg_sel), .seg_base(seg_base),
        .protected_mode(protected_mode), .paging_en(paging_en), .page_frame(page_frame),
        .resp_valid(resp_valid), .resp(resp), .index_fault(index_fault));

    bus_far_side far (.clk(clk), .sys_rst(sys_rst), .resp_valid(resp_valid), .resp(resp),
        .port_claim_q(port_claim_q));

    // ==========================================
    // shared tasks
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out

    function automatic req_t mk(input ref_t k, input logic [2:0] b);
        req_t r;
        r = '0;
        r.kind = k;
        r.use_base = 1'b1;
        r.base_idx = b;
        return r;
    endfunction : mk

    // request held until the edge that takes it; answer seen one cycle later
    task automatic issue(input req_t r);
        @(negedge clk);
        req = r;
        req_valid = 1'b1;
        waits = 0;
        // ready is combinational from the request: let it settle before looking
        #1;
        while (req_ready !== 1'b1 && waits < 8) begin
            @(negedge clk);
            #1;
            waits++;
        end
        @(negedge clk);
        req_valid = 1'b0;
        `CHK("resp_valid", 1'b1, resp_valid)
    endtask : issue

    // ==========================================
    // scenarios
    task automatic t_ea();
        req_t r;
        logic [ADDR_W-1:0] ea, lin;
        r = mk(REF_DATA, 3'h7);
        r.use_index = 1'b1;
        r.index_idx = 3'h6;
        r.scale_log2 = 2'h3;
        r.disp_kind = DISP_8;
        r.disp = 32'h0000_0080;
        issue(r);
        ea = gpr[7] + (gpr[6] << 3) + 32'hFFFF_FF80;
        lin = (ADDR_W'(seg_sel[SEG_DATA]) << REAL_SHIFT) + ea;
        `CHK("base index wait", 1, waits)
        `CHK("offset", ea, resp.offset)
        `CHK("real linear", lin, resp.linear)
        `CHK("phys", lin, resp.phys)
        `CHK("fault", 1'b0, index_fault)
        for (int s = 0; s < 4; s++) begin
            r = mk(REF_DATA, 3'h0);
            r.use_base = 1'b0;
            r.use_index = 1'b1;
            r.index_idx = 3'h2;
            r.scale_log2 = 2'(s);
            r.disp_kind = DISP_32;
            r.disp = 32'h8000_0001;
            issue(r);
            `CHK("single wait", 0, waits)
            `CHK("scaled", (gpr[2] << s) + 32'h8000_0001, resp.offset)
        end
        r = mk(REF_DATA, 3'h0);
        r.use_base = 1'b0;
        r.disp_kind = DISP_8;
        r.disp = 32'h1234_56FE;
        issue(r);
        `CHK("short disp", 32'hFFFF_FFFE, resp.offset)
        `CHK("short wait", 0, waits)
        r = mk(REF_DATA, 3'h4);
        r.use_base = 1'b0;
        r.use_index = 1'b1;
        r.index_idx = 3'h4;
        issue(r);
        `CHK("sp index fault", 1'b1, index_fault)
    endtask : t_ea

    task automatic t_seg();
        req_t r;
        ref_t kinds [4] = '{REF_CODE, REF_STACK_PUSH, REF_STACK_POP, REF_STRING_DST};
        seg_t segs [4] = '{SEG_CODE, SEG_STACK, SEG_STACK, SEG_EXTRA};
        for (int k = 0; k < 4; k++) begin
            r = mk(kinds[k], 3'h7);
            r.ovr_valid = 1'b1;
            r.ovr_seg = SEG_AUX_TWO;
            issue(r);
            `CHK("fixed seg", segs[k], resp.seg)
        end
        `CHK("string dst", gpr[7], resp.offset)
        issue(mk(REF_CODE, 3'h1));
        `CHK("code ofs", instr_ptr, resp.offset)
        for (int b = 0; b < 8; b++) begin
            issue(mk(REF_DATA, 3'(b)));
            `CHK("default seg", (b == 4 || b == 5) ? SEG_STACK : SEG_DATA, resp.seg)
        end
        protected_mode = 1'b1;
        for (int s = 0; s < 6; s++) begin
            r = mk(REF_DATA, 3'h5);
            r.ovr_valid = 1'b1;
            r.ovr_seg = seg_t'(s);
            issue(r);
            `CHK("ovr seg", seg_t'(s), resp.seg)
            `CHK("prot linear", seg_base[s] + gpr[5], resp.linear)
        end
    endtask : t_seg

    task automatic t_io_page();
        req_t r;
        paging_en = 1'b1;
        r = mk(REF_IO, 3'h3);
        r.io_imm = 1'b1;
        r.io_imm_port = 8'hF9;
        issue(r);
        `CHK("io imm", 32'h0000_00F9, resp.phys)
        `CHK("mem_io_n", 1'b0, resp.mem_io_n)
        `CHK("reserved", 1'b1, resp.io_reserved)
        `CHK("byte lane", 4'b0010, resp.byte_en)
        r.io_imm = 1'b0;
        r.size = SIZE_HALF;
        issue(r);
        `CHK("io index", 32'h0000_3333, resp.phys)
        `CHK("half lanes", 4'b1000, resp.byte_en)
        `CHK("not reserved", 1'b0, resp.io_reserved)
        @(negedge clk);
        `CHK("port claim", 1'b1, port_claim_q)
        for (int s = 0; s < 6; s++) begin
            seg_base[s] = ADDR_ZERO;
        end
        r = mk(REF_DATA, 3'h4);
        r.size = SIZE_WORD;
        issue(r);
        `CHK("flat", gpr[4], resp.linear)
        `CHK("paged", {page_frame[31:12], gpr[4][11:0]}, resp.phys)
        `CHK("word lanes", 4'b1111, resp.byte_en)
        `CHK("mem cycle", 1'b1, resp.mem_io_n)
    endtask : t_io_page

    // ==========================================
    // clock, timeout and main sequence
    initial begin
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        for (int i = 0; i < 8; i++) begin
            gpr[i] = ADDR_W'(32'h1111_1111 * i);
        end
        for (int i = 0; i < 6; i++) begin
            seg_sel[i] = SEL_W'(16'h1111 * (i + 1));
            seg_base[i] = ADDR_W'(32'h0100_0000 * (i + 1));
        end
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        `CHK("rst valid", 1'b0, resp_valid)
        `CHK("rst space", 1'b1, resp.mem_io_n)
        t_ea();
        t_seg();
        t_io_page();
        close_out();
    end
endmodule : segmented_address_generation_tb

`default_nettype wire
